// ==== asbt_buf_ram.sv ====
// 32-byte buffer RAM in flip-flops, one shared port, combinational read
`timescale 1ns/1ps
`default_nettype none

module asbt_buf_ram #(
    parameter int DEPTH = 32
) (
    input  wire logic      sys_clk,
    asbt_ram_if.ram_mp     ram
);
    logic [7:0] mem_r [DEPTH];

    always_ff @(posedge sys_clk) begin
        if (ram.we) begin
            mem_r[ram.addr] <= ram.wdata;
        end
    end

    assign ram.rdata = mem_r[ram.addr];
endmodule // asbt_buf_ram

`default_nettype wire

// ==== asbt_if.sv ====
// Carriers between the system-side engine, the link shifter and the buffer RAM
`timescale 1ns/1ps
`default_nettype none

interface asbt_link_if;
    logic [7:0] tx_byte;
    logic       req_tgl;
    logic       active;
    logic       done_tgl;
    logic [7:0] rx_byte;
    modport sys_mp  (output tx_byte, output req_tgl, output active,
                     input done_tgl, input rx_byte);
    modport link_mp (input tx_byte, input req_tgl, input active,
                     output done_tgl, output rx_byte);
endinterface // asbt_link_if

interface asbt_ram_if;
    logic [4:0] addr;
    logic       we;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport user_mp (output addr, output we, output wdata, input rdata);
    modport ram_mp  (input addr, input we, input wdata, output rdata);
endinterface // asbt_ram_if

`default_nettype wire

// ==== asbt_link.sv ====
// Serial shifter on the link clock; handshakes bytes with the system side
`timescale 1ns/1ps
`default_nettype none

module asbt_link
    import asbt_pkg::*;
(
    input  wire logic   sck_clk,
    input  wire logic   rst,
    input  wire logic   sin,
    asbt_link_if.link_mp lnk,
    output logic        sout
);
    logic       req_s1_r, req_s2_r, req_s3_r;
    logic       act_s1_r, act_s2_r;
    logic [7:0] sh_r;
    logic [3:0] cnt_r;
    logic       done_tgl_r;
    logic [7:0] rx_r;
    logic       sout_r;
    logic       load;

    always_ff @(posedge sck_clk or posedge rst) begin
        if (rst) begin
            req_s1_r <= 1'b0;
            req_s2_r <= 1'b0;
            req_s3_r <= 1'b0;
            act_s1_r <= 1'b0;
            act_s2_r <= 1'b0;
        end else begin
            req_s1_r <= lnk.req_tgl;
            req_s2_r <= req_s1_r;
            req_s3_r <= req_s2_r;
            act_s1_r <= lnk.active;
            act_s2_r <= act_s1_r;
        end
    end

    assign load = (req_s2_r ^ req_s3_r) && (cnt_r == 4'h0);

    // Eight bits out MSB first, input sampled on the same edges
    always_ff @(posedge sck_clk or posedge rst) begin
        if (rst) begin
            sh_r       <= 8'h00;
            cnt_r      <= 4'h0;
            done_tgl_r <= 1'b0;
            rx_r       <= 8'h00;
        end else if (load) begin
            sh_r  <= lnk.tx_byte;
            cnt_r <= BYTE_BITS;
        end else if (cnt_r != 4'h0) begin
            sh_r  <= {sh_r[6:0], sin};
            cnt_r <= cnt_r - 4'h1;
            if (cnt_r == 4'h1) begin
                rx_r       <= {sh_r[6:0], sin};
                done_tgl_r <= ~done_tgl_r;
            end
        end
    end

    always_ff @(posedge sck_clk or posedge rst) begin
        if (rst) begin
            sout_r <= 1'b0;
        end else if (!act_s2_r) begin
            sout_r <= 1'b0;
        end else if (load) begin
            sout_r <= lnk.tx_byte[7];
        end else if (cnt_r > 4'h1) begin
            sout_r <= sh_r[6];
        end
    end

    assign lnk.done_tgl = done_tgl_r;
    assign lnk.rx_byte  = rx_r;
    assign sout         = sout_r;

    chk_sout_low_idle: assert property (@(posedge sck_clk) disable iff (rst)
        !act_s2_r |=> !sout_r)
        else $error("serial output not low while transfer inactive");

    chk_eight_bit_byte: assert property (@(posedge sck_clk) disable iff (rst)
        load |=> (cnt_r != 4'h0)[*8] ##1 (cnt_r == 4'h0))
        else $error("byte did not take exactly eight link clocks");

    cov_byte_shifted: cover property (@(posedge sck_clk) disable iff (rst)
        load ##9 (cnt_r == 4'h0));
endmodule // asbt_link

`default_nettype wire

// ==== asbt_peer.sv ====
// Serial peripheral model: link clock, reply data, count of ones sent
`timescale 1ns/1ps
`default_nettype none
module asbt_peer (
    input  wire logic        run,
    input  wire logic        reply,
    input  wire logic        sout,
    output logic             sck_clk,
    output logic             sin,
    output logic [15:0]      ones
);
    logic [15:0] ones_r = 16'h0000;

    initial begin
        sck_clk = 1'b0;
        #7;
        forever #15 sck_clk = run ? ~sck_clk : 1'b0;
    end
    // Released line shows the inverse level
    assign sin = run ? reply : ~reply;
    always @(posedge sck_clk) if (sout) ones_r <= ones_r + 16'h0001;
    assign ones = ones_r;
endmodule // asbt_peer
`default_nettype wire

// ==== asbt_pkg.sv ====
// Shared constants, state codes and helpers of the automatic serial buffer transfer block
package asbt_pkg;

    // CPU register addresses
    localparam logic [15:0] ADDR_SHIFT    = 16'hFF68;
    localparam logic [15:0] ADDR_MODE     = 16'hFF69;
    localparam logic [15:0] ADDR_CTRL     = 16'hFF6A;
    localparam logic [15:0] ADDR_INTERVAL = 16'hFF6B;
    localparam logic [15:0] ADDR_PTR      = 16'hFF6C;
    localparam logic [15:0] ADDR_PORT     = 16'hFF6D;
    localparam logic [15:0] ADDR_IRQ      = 16'hFF6E;
    localparam logic [15:0] ADDR_BUF_LO   = 16'hFAC0;
    localparam logic [15:0] ADDR_BUF_HI   = 16'hFADF;

    // Field positions
    localparam int MODE_PORT_ON_BIT  = 7;
    localparam int MODE_AUTO_SEL_BIT = 5;
    localparam int CTRL_RX_ON_BIT    = 7;
    localparam int CTRL_ACTIVE_BIT   = 3;
    localparam int INTERVAL_ON_BIT   = 7;
    localparam int IRQ_FLAG_BIT      = 0;

    // Reset values and writable masks
    localparam logic [7:0] MODE_RST          = 8'h00;
    localparam logic [7:0] CTRL_RST          = 8'h00;
    localparam logic [7:0] INTERVAL_RST      = 8'h00;
    localparam logic [4:0] PTR_RST           = 5'h00;
    localparam logic [3:0] PORT_RST          = 4'h0;
    localparam logic [7:0] CTRL_WR_MASK      = 8'hE7;
    localparam logic [7:0] INTERVAL_WR_MASK  = 8'h9F;

    // Cycle counts in main-clock periods; BYTE_BITS counts link clocks
    localparam int          INTERVAL_UNIT_CYC  = 128;
    localparam int          INTERVAL_BASE_CYC  = 56;
    localparam int          INTERVAL_SLACK_CYC = 72;
    localparam int          GAP_W              = 13;
    localparam logic [GAP_W-1:0] GAP_FREE_CYC  = 13'h0001;
    localparam logic [3:0]  BYTE_BITS          = 4'h8;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_LOAD  = 5'b00010,
        ST_SEND  = 5'b00100,
        ST_STORE = 5'b01000,
        ST_GAP   = 5'b10000
    } asbt_state_e;

    // Inter-byte wait in main-clock cycles
    function automatic logic [GAP_W-1:0] asbt_gap_cycles(input logic       on,
                                                         input logic [4:0] code,
                                                         input int         unit,
                                                         input int         base);
        int total;
        total = (int'(code) + 1) * unit + base;
        return on ? total[GAP_W-1:0] : GAP_FREE_CYC;
    endfunction

endpackage

// ==== asbt_top.sv ====
// Automatic serial buffer transfer engine with CPU registers and buffer RAM
//
// Contract
// - Interval gap is (n+1)*128 plus 56 to 72 main clocks plus link slack.
// - Gap never shorter than two serial clock periods.
// - With interval control on, the busy input has no effect.
// - In automatic mode the trigger value written to the shift register is never sent; in plain mode it is the byte sent.
// - On trigger, the byte at the pointer is loaded and shifted out.
// - Each received byte is stored at the current pointer address.
// - Pointer decrements per byte until the lowest address byte is sent.
// - Transfer-in-progress flag clears when the sequence ends.
// - Data is exchanged in whole bytes; a shift register write starts it.
// - Interrupt request flag sets after the final byte completes.
// - Strobe and busy pins stay general purpose port pins.
// - Engine RAM access after each byte waits behind CPU accesses.
// - Serial output is low whenever the in-progress flag is clear; the code drives it low from the third link clock edge after the flag clears.
// - Interval bit 0 gives CPU-bound gap; 1 uses the five-bit code.
// - Mode bit 0 gives plain serial, 1 gives automatic buffer transfer.
// - Control register resets to zero; progress and error bits read-only.
`timescale 1ns/1ps
`default_nettype none

module asbt_top
    import asbt_pkg::*;
#(
    parameter int INTERVAL_UNIT = INTERVAL_UNIT_CYC,
    parameter int INTERVAL_BASE = INTERVAL_BASE_CYC
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        sck_clk,
    input  wire logic [15:0] cpu_addr,
    input  wire logic        cpu_wr_en,
    input  wire logic        cpu_rd_en,
    input  wire logic [7:0]  cpu_wdata,
    output logic      [7:0]  cpu_rdata,
    input  wire logic        serial_in_pin,
    output logic             serial_out_pin,
    output logic             serial_done_interrupt,
    input  wire logic        port_pin_strobe_shared_i,
    output logic             port_pin_strobe_shared_o,
    output logic             port_pin_strobe_shared_oe,
    input  wire logic        port_pin_busy_shared_i,
    output logic             port_pin_busy_shared_o,
    output logic             port_pin_busy_shared_oe
);
    asbt_link_if lnk ();
    asbt_ram_if  ram ();

    asbt_state_e      st_r;
    logic [7:0]       serial_mode_reg_r;
    logic [7:0]       auto_xfer_ctrl_reg_r;
    logic [7:0]       transfer_interval_select_r;
    logic [4:0]       buffer_pointer_r;
    logic [3:0]       port_r;
    logic             serial_done_irq_flag_r;
    logic             irq_pulse_r;
    logic [7:0]       shift_rx_r;
    logic [7:0]       tx_r;
    logic             req_tgl_r;
    logic             xfer_active_flag_r;
    logic             auto_r;
    logic [GAP_W-1:0] gap_cnt_r;
    logic [7:0]       cpu_rdata_r;
    logic             done_s1_r, done_s2_r, done_s3_r;
    logic [1:0]       pin_s1_r, pin_s2_r;

    logic cpu_buf;
    logic wr_shift;
    logic start;
    logic done_evt;
    logic store_ok;
    logic finish;
    logic eng_we;

    // Decode
    assign cpu_buf  = (cpu_wr_en || cpu_rd_en)
                      && (cpu_addr >= ADDR_BUF_LO) && (cpu_addr <= ADDR_BUF_HI);
    assign wr_shift = cpu_wr_en && (cpu_addr == ADDR_SHIFT);
    assign start    = (st_r == ST_IDLE) && wr_shift
                      && serial_mode_reg_r[MODE_PORT_ON_BIT];
    assign done_evt = done_s2_r ^ done_s3_r;
    assign store_ok = (st_r == ST_STORE) && !cpu_buf;
    assign finish   = (st_r == ST_STORE) && (!auto_r || (store_ok && buffer_pointer_r == 5'h00));
    assign eng_we   = store_ok && auto_r && auto_xfer_ctrl_reg_r[CTRL_RX_ON_BIT];

    // Buffer RAM port: CPU first, engine takes the idle cycles
    always_comb begin
        if (cpu_buf) begin
            ram.addr  = cpu_addr[4:0];
            ram.we    = cpu_wr_en;
            ram.wdata = cpu_wdata;
        end else begin
            ram.addr  = buffer_pointer_r;
            ram.we    = eng_we;
            ram.wdata = lnk.rx_byte;
        end
    end

    asbt_buf_ram #(
        .DEPTH (32)
    ) u_ram (
        .sys_clk (sys_clk),
        .ram     (ram)
    );

    assign lnk.tx_byte = tx_r;
    assign lnk.req_tgl = req_tgl_r;
    assign lnk.active  = xfer_active_flag_r;

    asbt_link u_link (
        .sck_clk (sck_clk),
        .rst     (rst),
        .sin     (serial_in_pin),
        .lnk     (lnk),
        .sout    (serial_out_pin)
    );

    // Synchronisers from the link and the pins
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            done_s1_r <= 1'b0;
            done_s2_r <= 1'b0;
            done_s3_r <= 1'b0;
            pin_s1_r  <= 2'h0;
            pin_s2_r  <= 2'h0;
        end else begin
            done_s1_r <= lnk.done_tgl;
            done_s2_r <= done_s1_r;
            done_s3_r <= done_s2_r;
            pin_s1_r  <= {port_pin_busy_shared_i, port_pin_strobe_shared_i};
            pin_s2_r  <= pin_s1_r;
        end
    end

    // Sequencer
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_r <= ST_IDLE;
        end else begin
            case (st_r)
                ST_IDLE: begin
                    if (start) begin
                        st_r <= serial_mode_reg_r[MODE_AUTO_SEL_BIT] ? ST_LOAD : ST_SEND;
                    end
                end
                ST_LOAD: begin
                    if (!cpu_buf) begin
                        st_r <= ST_SEND;
                    end
                end
                ST_SEND: begin
                    if (done_evt) begin
                        st_r <= ST_STORE;
                    end
                end
                ST_STORE: begin
                    if (finish) begin
                        st_r <= ST_IDLE;
                    end else if (store_ok) begin
                        st_r <= ST_GAP;
                    end
                end
                ST_GAP: begin
                    if (gap_cnt_r == GAP_FREE_CYC) begin
                        st_r <= ST_LOAD;
                    end
                end
                default: st_r <= ST_IDLE;
            endcase
        end
    end

    // Byte handed to the link; the trigger value is dropped in auto mode
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tx_r      <= 8'h00;
            req_tgl_r <= 1'b0;
            auto_r    <= 1'b0;
        end else if (start) begin
            auto_r <= serial_mode_reg_r[MODE_AUTO_SEL_BIT];
            if (!serial_mode_reg_r[MODE_AUTO_SEL_BIT]) begin
                tx_r      <= cpu_wdata;
                req_tgl_r <= ~req_tgl_r;
            end
        end else if ((st_r == ST_LOAD) && !cpu_buf) begin
            tx_r      <= ram.rdata;
            req_tgl_r <= ~req_tgl_r;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            xfer_active_flag_r <= 1'b0;
        end else if (start) begin
            xfer_active_flag_r <= 1'b1;
        end else if (finish) begin
            xfer_active_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            buffer_pointer_r <= PTR_RST;
        end else if (store_ok && auto_r && (buffer_pointer_r != 5'h00)) begin
            buffer_pointer_r <= buffer_pointer_r - 5'h01;
        end else if (cpu_wr_en && (cpu_addr == ADDR_PTR)) begin
            buffer_pointer_r <= cpu_wdata[4:0];
        end
    end

    // Inter-byte wait; busy pin never enters here
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            gap_cnt_r <= GAP_FREE_CYC;
        end else if (store_ok && !finish) begin
            gap_cnt_r <= asbt_gap_cycles(transfer_interval_select_r[INTERVAL_ON_BIT],
                                         transfer_interval_select_r[4:0],
                                         INTERVAL_UNIT, INTERVAL_BASE);
        end else if ((st_r == ST_GAP) && (gap_cnt_r != GAP_FREE_CYC)) begin
            gap_cnt_r <= gap_cnt_r - GAP_FREE_CYC;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            shift_rx_r <= 8'h00;
        end else if ((st_r == ST_STORE) && done_s3_r == done_s2_r) begin
            shift_rx_r <= lnk.rx_byte;
        end
    end

    // Completion flag: setting wins over a clearing write
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            serial_done_irq_flag_r <= 1'b0;
            irq_pulse_r            <= 1'b0;
        end else begin
            irq_pulse_r <= finish;
            if (finish) begin
                serial_done_irq_flag_r <= 1'b1;
            end else if (cpu_wr_en && (cpu_addr == ADDR_IRQ) && !cpu_wdata[IRQ_FLAG_BIT]) begin
                serial_done_irq_flag_r <= 1'b0;
            end
        end
    end

    // Software registers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            serial_mode_reg_r          <= MODE_RST;
            auto_xfer_ctrl_reg_r       <= CTRL_RST;
            transfer_interval_select_r <= INTERVAL_RST;
            port_r                     <= PORT_RST;
        end else if (cpu_wr_en) begin
            case (cpu_addr)
                ADDR_MODE:     serial_mode_reg_r <= cpu_wdata;
                ADDR_CTRL:     auto_xfer_ctrl_reg_r <= cpu_wdata & CTRL_WR_MASK;
                ADDR_INTERVAL: transfer_interval_select_r <= cpu_wdata & INTERVAL_WR_MASK;
                ADDR_PORT:     port_r <= cpu_wdata[3:0];
                default:       port_r <= port_r;
            endcase
        end
    end

    // Read data, one cycle after the request
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cpu_rdata_r <= 8'h00;
        end else if (cpu_rd_en) begin
            if (cpu_buf) begin
                cpu_rdata_r <= ram.rdata;
            end else begin
                case (cpu_addr)
                    ADDR_SHIFT:    cpu_rdata_r <= shift_rx_r;
                    ADDR_MODE:     cpu_rdata_r <= serial_mode_reg_r;
                    ADDR_CTRL:     cpu_rdata_r <= auto_xfer_ctrl_reg_r
                                                  | {4'h0, xfer_active_flag_r, 3'h0};
                    ADDR_INTERVAL: cpu_rdata_r <= transfer_interval_select_r;
                    ADDR_PTR:      cpu_rdata_r <= {3'h0, buffer_pointer_r};
                    ADDR_PORT:     cpu_rdata_r <= {2'h0, pin_s2_r, port_r};
                    ADDR_IRQ:      cpu_rdata_r <= {7'h00, serial_done_irq_flag_r};
                    default:       cpu_rdata_r <= 8'h00;
                endcase
            end
        end
    end

    assign cpu_rdata                 = cpu_rdata_r;
    assign serial_done_interrupt     = irq_pulse_r;
    assign port_pin_strobe_shared_o  = port_r[0];
    assign port_pin_busy_shared_o    = port_r[1];
    assign port_pin_strobe_shared_oe = port_r[2];
    assign port_pin_busy_shared_oe   = port_r[3];

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    logic [GAP_W-1:0] gap_seen_r;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            gap_seen_r <= '0;
        end else if (st_r == ST_GAP) begin
            gap_seen_r <= gap_seen_r + GAP_FREE_CYC;
        end else begin
            gap_seen_r <= '0;
        end
    end

    chk_gap_length: assert property (
        (st_r == ST_GAP) && (gap_cnt_r == GAP_FREE_CYC) |->
        (gap_seen_r + GAP_FREE_CYC) == asbt_gap_cycles(transfer_interval_select_r[INTERVAL_ON_BIT],
                                                       transfer_interval_select_r[4:0],
                                                       INTERVAL_UNIT, INTERVAL_BASE))
        else $error("inter-byte wait differs from interval setting");

    chk_load_at_pointer: assert property (
        (st_r == ST_LOAD) && !cpu_buf |=> (tx_r == $past(ram.rdata)) && (st_r == ST_SEND))
        else $error("byte loaded for sending is not the addressed buffer byte");

    chk_trigger_dropped: assert property (
        start && serial_mode_reg_r[MODE_AUTO_SEL_BIT] |=> $stable(tx_r) && (st_r == ST_LOAD))
        else $error("trigger value reached the shifter");

    chk_rx_store_addr: assert property (
        store_ok && auto_r && auto_xfer_ctrl_reg_r[CTRL_RX_ON_BIT] |->
        ram.we && (ram.addr == buffer_pointer_r) && (ram.wdata == lnk.rx_byte))
        else $error("received byte not written at the pointer");

    chk_ptr_decrement: assert property (
        store_ok && auto_r && (buffer_pointer_r != 5'h00) |=>
        (buffer_pointer_r == $past(buffer_pointer_r) - 5'h01) && (st_r == ST_GAP))
        else $error("pointer not decremented after a byte");

    chk_end_clears_flag: assert property (
        finish |=> !xfer_active_flag_r && (st_r == ST_IDLE))
        else $error("in-progress flag still set after sequence end");

    chk_end_sets_irq: assert property (
        finish |=> serial_done_irq_flag_r && serial_done_interrupt ##1 !serial_done_interrupt)
        else $error("interrupt request missing at sequence end");

    chk_cpu_ram_first: assert property (
        cpu_buf && auto_r && (st_r == ST_STORE) |-> !eng_we ##1 (st_r == ST_STORE))
        else $error("engine took the buffer during a CPU access");

    chk_ctrl_ro_bits: assert property (
        cpu_wr_en && (cpu_addr == ADDR_CTRL) |=> (auto_xfer_ctrl_reg_r[4:3] == 2'h0))
        else $error("read-only control bits became writable");

    cov_auto_sequence: cover property (
        start && serial_mode_reg_r[MODE_AUTO_SEL_BIT] ##[1:1000] finish);

    cov_plain_byte: cover property (
        start && !serial_mode_reg_r[MODE_AUTO_SEL_BIT] ##[1:200] finish);

    cov_timed_gap: cover property (
        (st_r == ST_GAP) && transfer_interval_select_r[INTERVAL_ON_BIT] ##1 (st_r == ST_LOAD));

endmodule // asbt_top

`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench of the automatic serial buffer transfer block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import asbt_pkg::*;
    logic        sys_clk, rst, sck_clk, wr_en, rd_en, sin, sout, irq, run, reply;
    logic        stb_i, bsy_i, stb_o, stb_oe, bsy_o, bsy_oe;
    logic [15:0] addr, ones;
    logic [7:0]  wdata, rdata, v;
    int          fail_count, num_checks, irqs, cycles;
    localparam logic [31:0] ROWS [5] = '{{ADDR_INTERVAL, 16'hFF9F}, {ADDR_CTRL, 16'hFFE7},
        {ADDR_PTR, 16'hFF1F}, {16'hFF70, 16'h5500}, {ADDR_PORT, 16'h0F1F}};
    localparam logic [7:0] BYTES [3] = '{8'h42, 8'h24, 8'h18};
    asbt_top #(.INTERVAL_UNIT(4), .INTERVAL_BASE(2)) asbt_top_inst (.sys_clk(sys_clk),
        .rst(rst), .sck_clk(sck_clk), .cpu_addr(addr), .cpu_wr_en(wr_en),
        .cpu_rd_en(rd_en), .cpu_wdata(wdata), .cpu_rdata(rdata), .serial_in_pin(sin),
        .serial_out_pin(sout), .serial_done_interrupt(irq),
        .port_pin_strobe_shared_i(stb_i), .port_pin_strobe_shared_o(stb_o),
        .port_pin_strobe_shared_oe(stb_oe), .port_pin_busy_shared_i(bsy_i),
        .port_pin_busy_shared_o(bsy_o), .port_pin_busy_shared_oe(bsy_oe));
    asbt_peer asbt_peer_inst (.run(run), .reply(reply), .sout(sout), .sck_clk(sck_clk),
        .sin(sin), .ones(ones));
    always #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles++;
        if (irq === 1'b1) irqs++;
        if (cycles == 20000) begin
            fail_count++;
            wrap_up();
        end
    end
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge sys_clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a);
        @(posedge sys_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic wait_idle;
        repeat (4) @(posedge sys_clk);
        repeat (400) begin
            rd(ADDR_BUF_HI);
            rd(ADDR_CTRL);
            if (v[CTRL_ACTIVE_BIT] === 1'b0) return;
        end
        chk("idle", 16'h0000, 16'h0001);
    endtask
    task automatic wrap_up;
        $display("Checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        {sys_clk, wr_en, rd_en, run, reply, bsy_i} = 6'h00;
        {rst, stb_i, addr, wdata} = {2'b11, 24'h000000};
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        foreach (ROWS[i]) begin
            rd(ROWS[i][31:16]);
            chk("reset", (ROWS[i][31:16] == ADDR_PORT) ? 16'h0010 : 16'h0000, v);
        end
        foreach (ROWS[i]) begin
            wr(ROWS[i][31:16], ROWS[i][15:8]);
            rd(ROWS[i][31:16]);
            chk("reg", ROWS[i][7:0], v);
        end
        chk("port", 16'h000F, {stb_oe, bsy_oe, stb_o, bsy_o});
        $display("Test registers done");
        run <= 1'b1;
        reply <= 1'b1;
        bsy_i <= 1'b1;
        wr(ADDR_MODE, 8'hA0);
        wr(ADDR_CTRL, 8'h80);
        wr(ADDR_INTERVAL, 8'h81);
        wr(ADDR_PTR, 8'h02);
        foreach (BYTES[i]) wr(ADDR_BUF_LO + 16'(i), BYTES[i]);
        wr(ADDR_SHIFT, 8'hFF);
        wait_idle();
        chk("ones", 16'h0006, ones);
        foreach (BYTES[i]) begin
            rd(ADDR_BUF_LO + 16'(i));
            chk("rx", 16'h00FF, v);
        end
        rd(ADDR_PTR);
        chk("ptr", 16'h0000, v);
        rd(ADDR_IRQ);
        chk("irqflag", 16'h0001, 16'(v[IRQ_FLAG_BIT]));
        chk("sout", 16'h0000, 16'(sout));
        $display("Test auto done");
        wr(ADDR_IRQ, 8'h00);
        reply <= 1'b0;
        wr(ADDR_MODE, 8'h80);
        wr(ADDR_SHIFT, 8'h3C);
        wait_idle();
        chk("ones", 16'h000A, ones);
        rd(ADDR_SHIFT);
        chk("rx", 16'h0000, v);
        rd(ADDR_IRQ);
        chk("irqflag", 16'h0001, 16'(v[IRQ_FLAG_BIT]));
        chk("pulses", 16'h0002, 16'(irqs));
        $display("Test plain done");
        wr(ADDR_MODE, 8'hA0);
        wr(ADDR_INTERVAL, 8'h00);
        wr(ADDR_PTR, 8'h01);
        wr(ADDR_BUF_LO, 8'h42);
        wr(ADDR_BUF_LO + 16'h0001, 8'h18);
        wr(ADDR_SHIFT, 8'h00);
        wait_idle();
        chk("ones", 16'h000E, ones);
        rd(ADDR_BUF_LO + 16'h0001);
        chk("rx", 16'h0000, v);
        rd(ADDR_PTR);
        chk("ptr", 16'h0000, v);
        $display("Test untimed done");
        wrap_up();
    end
endmodule // tb_top
`default_nettype wire
